// ===== hw/ppm_pkg.sv
// Package for the parallel programmer mode flash sequencer
package ppm_pkg;
   localparam int unsigned ADDR_W     = 19;
   localparam int unsigned PAGE_BYTES = 128;
   localparam int unsigned PAGE_LSB   = 7;
   localparam int unsigned ARRAY_BYTES = 1024;
   localparam int unsigned CLK_MHZ    = 200;
   // Oscillator plus mode setup time, in microseconds
   localparam int unsigned SETUP_US   = 10000;
   localparam int unsigned SETUP_CYC  = SETUP_US * CLK_MHZ;
   localparam int unsigned PROG_CYC_DEF  = 64;
   localparam int unsigned ERASE_CYC_DEF = 256;
   localparam logic [7:0] CMD_READ_USER   = 8'h00;
   localparam logic [7:0] CMD_READ_BOOT   = 8'h05;
   localparam logic [7:0] CMD_PROG_USER   = 8'h40;
   localparam logic [7:0] CMD_PROG_BOOT   = 8'h45;
   localparam logic [7:0] CMD_ERASE_USER  = 8'h20;
   localparam logic [7:0] CMD_ERASE_BOOT  = 8'h25;
   localparam logic [7:0] CMD_STATUS      = 8'h71;
   localparam logic [7:0] ERASED_BYTE     = 8'hff;
   localparam int unsigned ST_ABN = 7;
   localparam int unsigned ST_CMD = 6;
   localparam int unsigned ST_PRG = 5;
   localparam int unsigned ST_ERS = 4;
   localparam int unsigned ST_CNT = 1;
   localparam int unsigned ST_ADR = 0;
   typedef enum logic [1:0] {
      PPM_NONE, PPM_READ, PPM_WRITE
   } ppm_cyc_t;
   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } ppm_bus_t;
endpackage : ppm_pkg

// ===== hw/ppm_seq.sv
// Sequencer for the parallel programmer mode of an on-chip flash
`timescale 1ns/1ps
// What this block does
// - After program, erase or status read, wait for a new command
// - Memory-read mode takes commands and any number of reads
// - After setup period the device comes up in memory-read mode
// - Commands are ignored until the setup period has elapsed
// - Auto-program takes one 128-byte page in consecutive writes
// - Page address low seven bits nonzero: busy period runs but array write skipped, error flagged
// - Page address captured on second cycle, later addresses ignored
// - A page is programmed once; reprogram needs erase first
// - Auto-erase clears the whole selected array at once
// - Polling bits held until next command, driven on CE and OE low
// - Bit 7 is 0 while busy, 1 when done; bits 0 to 5 are 0
// - Bit 6 is 1 for normal end, 0 for abnormal end
// - Status read reports why an operation ended abnormally
// - Status code holds until a command for another mode
// - Status bits reset to 0; flags abnormal, cmd, prog, count, addr; erase bit 4 is never set
// - No product identification read mode exists
// - Select, output enable and write strobes decode the bus cycle
// - Command codes select mode and user or boot array
module ppm_seq
   import ppm_pkg::*;
#(
   parameter int unsigned SETUP_CYCLES = SETUP_CYC,
   parameter int unsigned PROG_CYCLES  = PROG_CYC_DEF,
   parameter int unsigned ERASE_CYCLES = ERASE_CYC_DEF
) (
   input  wire logic             clk_sys,    // System clock
   input  wire logic             rst_n,      // Synchronous reset
   input  wire ppm_pkg::ppm_bus_t bus,       // Programmer strobes and lines
   output logic [7:0]            data_out,   // Data bus output
   output logic [7:0]            data_oe,    // Data bus output enable
   output logic                  ready,      // Setup period over
   output logic                  busy,       // Program or erase running
   output logic                  boot_array  // Boot array selected
);
   import ppm_pkg::*;

   typedef enum logic [2:0] {
      S_SETUP, S_READ, S_WAIT, S_PADDR, S_PDATA, S_ERASE2, S_STAT2, S_BUSY
   } ppm_state_t;
   typedef enum logic [1:0] { O_MEM, O_POLL, O_STAT } ppm_out_t;

   localparam int unsigned ARR_W = $clog2(ARRAY_BYTES);
   localparam int unsigned PG_N  = ARRAY_BYTES / PAGE_BYTES;

   logic [7:0] mem_user [ARRAY_BYTES];
   logic [7:0] mem_boot [ARRAY_BYTES];
   logic [7:0] pagebuf  [PAGE_BYTES];

   ppm_state_t state_r, state_nxt;
   ppm_out_t   omode_r, omode_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic [7:0]  stat_r, stat_nxt;
   logic [1:0]  poll_r, poll_nxt;
   logic        boot_r, boot_nxt;
   logic        op_prog_r, op_prog_nxt;
   logic [ADDR_W-1:0] page_r, page_nxt;
   logic [6:0]  idx_r, idx_nxt;
   logic [PG_N-1:0] done_u_r, done_u_nxt, done_b_r, done_b_nxt;
   logic        we_d_r;
   ppm_bus_t    bus_d_r;
   logic        wr_ev;
   logic        rd_cyc;
   logic        do_prog, do_erase;
   logic [ARR_W-1:0] pg_base;
   logic [$clog2(PG_N)-1:0] pg_idx;

   // Strobes are taken as synchronous: one register stage plus a delayed
   // write strobe turns each write into a single-cycle event
   // Write completes on rising write strobe with select low
   assign wr_ev  = !bus_d_r.ce_n && bus_d_r.oe_n
                   && !we_d_r && bus_d_r.we_n;
   assign rd_cyc = !bus.ce_n && !bus.oe_n && bus.we_n;
   assign pg_idx = page_r[ARR_W-1:PAGE_LSB];
   assign pg_base = {pg_idx, 7'h00};

   always_comb begin
      state_nxt   = state_r;
      omode_nxt   = omode_r;
      cnt_nxt     = cnt_r;
      stat_nxt    = stat_r;
      poll_nxt    = poll_r;
      boot_nxt    = boot_r;
      op_prog_nxt = op_prog_r;
      page_nxt    = page_r;
      idx_nxt     = idx_r;
      done_u_nxt  = done_u_r;
      done_b_nxt  = done_b_r;
      do_prog     = 1'b0;
      do_erase    = 1'b0;
      unique case (state_r)
         S_SETUP: begin
            // Writes during setup are dropped
            if (cnt_r >= SETUP_CYCLES - 1) begin
               state_nxt = S_READ;
               omode_nxt = O_MEM;
               cnt_nxt   = 32'h0;
            end else begin
               cnt_nxt = cnt_r + 32'h1;
            end
         end
         S_READ, S_WAIT: begin
            if (wr_ev) begin
               poll_nxt = 2'b00;
               unique case (bus_d_r.data)
                  CMD_READ_USER, CMD_READ_BOOT: begin
                     boot_nxt  = bus_d_r.data == CMD_READ_BOOT;
                     state_nxt = S_READ;
                     omode_nxt = O_MEM;
                     stat_nxt  = 8'h00;
                  end
                  CMD_PROG_USER, CMD_PROG_BOOT: begin
                     boot_nxt  = bus_d_r.data == CMD_PROG_BOOT;
                     state_nxt = S_PADDR;
                     stat_nxt  = 8'h00;
                  end
                  CMD_ERASE_USER, CMD_ERASE_BOOT: begin
                     boot_nxt  = bus_d_r.data == CMD_ERASE_BOOT;
                     state_nxt = S_ERASE2;
                     stat_nxt  = 8'h00;
                  end
                  CMD_STATUS: state_nxt = S_STAT2;
                  default: begin
                     stat_nxt[ST_CMD] = 1'b1;
                     stat_nxt[ST_ABN] = 1'b1;
                     state_nxt = S_WAIT;
                     omode_nxt = O_STAT;
                  end
               endcase
            end
         end
         S_PADDR: begin
            if (wr_ev) begin
               page_nxt = bus_d_r.addr;
               idx_nxt  = 7'h01;
               if (bus_d_r.addr[PAGE_LSB-1:0] != 7'h00) begin
                  stat_nxt[ST_ADR] = 1'b1;
                  stat_nxt[ST_PRG] = 1'b1;
               end
               state_nxt = S_PDATA;
            end
         end
         S_PDATA: begin
            if (wr_ev) begin
               idx_nxt = idx_r + 7'h01;
               if (idx_r == 7'(PAGE_BYTES - 1)) begin
                  op_prog_nxt = 1'b1;
                  state_nxt   = S_BUSY;
                  omode_nxt   = O_POLL;
                  cnt_nxt     = 32'h0;
               end
            end
         end
         S_ERASE2: begin
            if (wr_ev) begin
               if (bus_d_r.data == (boot_r ? CMD_ERASE_BOOT
                                           : CMD_ERASE_USER)) begin
                  op_prog_nxt = 1'b0;
                  state_nxt   = S_BUSY;
                  omode_nxt   = O_POLL;
                  cnt_nxt     = 32'h0;
               end else begin
                  stat_nxt[ST_CMD] = 1'b1;
                  stat_nxt[ST_ABN] = 1'b1;
                  state_nxt = S_WAIT;
                  omode_nxt = O_STAT;
               end
            end
         end
         S_STAT2: begin
            if (wr_ev) begin
               if (bus_d_r.data != CMD_STATUS) begin
                  stat_nxt[ST_CMD] = 1'b1;
                  stat_nxt[ST_ABN] = 1'b1;
               end
               state_nxt = S_WAIT;
               omode_nxt = O_STAT;
            end
         end
         // A page is marked used even when a bad address skipped the write,
         // so a retry without erase still reports count exceeded
         S_BUSY: begin
            // Writes while busy are not decoded at all
            if (cnt_r >= (op_prog_r ? PROG_CYCLES : ERASE_CYCLES) - 1) begin
               state_nxt = S_WAIT;
               cnt_nxt   = 32'h0;
               if (op_prog_r) begin
                  if ((boot_r ? done_b_r[pg_idx] : done_u_r[pg_idx])) begin
                     stat_nxt[ST_PRG] = 1'b1;
                     stat_nxt[ST_CNT] = 1'b1;
                  end else if (!stat_r[ST_ADR]) begin
                     do_prog = 1'b1;
                  end
                  if (boot_r) done_b_nxt[pg_idx] = 1'b1;
                  else        done_u_nxt[pg_idx] = 1'b1;
               end else begin
                  do_erase = 1'b1;
                  if (boot_r) done_b_nxt = '0;
                  else        done_u_nxt = '0;
               end
               if (stat_nxt[ST_PRG] || stat_nxt[ST_CNT]
                   || stat_nxt[ST_ADR]) begin
                  stat_nxt[ST_ABN] = 1'b1;
                  poll_nxt = 2'b10;
               end else begin
                  poll_nxt = 2'b11;
               end
            end else begin
               cnt_nxt = cnt_r + 32'h1;
            end
         end
         default: state_nxt = S_SETUP;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      bus_d_r <= bus;
      we_d_r  <= bus_d_r.we_n;
      if (!rst_n) begin
         state_r   <= S_SETUP;
         omode_r   <= O_MEM;
         cnt_r     <= 32'h0;
         stat_r    <= 8'h00;
         poll_r    <= 2'b00;
         boot_r    <= 1'b0;
         op_prog_r <= 1'b0;
         page_r    <= '0;
         idx_r     <= 7'h00;
         done_u_r  <= '0;
         done_b_r  <= '0;
         we_d_r    <= 1'b1;
      end else begin
         state_r   <= state_nxt;
         omode_r   <= omode_nxt;
         cnt_r     <= cnt_nxt;
         stat_r    <= stat_nxt;
         poll_r    <= poll_nxt;
         boot_r    <= boot_nxt;
         op_prog_r <= op_prog_nxt;
         page_r    <= page_nxt;
         idx_r     <= idx_nxt;
         done_u_r  <= done_u_nxt;
         done_b_r  <= done_b_nxt;
      end
   end

   // Array storage, no reset: contents survive a chip reset like flash
   always_ff @(posedge clk_sys) begin
      if (state_r == S_PADDR && wr_ev)
         pagebuf[0] <= bus_d_r.data;
      if (state_r == S_PDATA && wr_ev)
         pagebuf[idx_r] <= bus_d_r.data;
      for (int i = 0; i < PAGE_BYTES; i++) begin
         if (do_prog && boot_r)
            mem_boot[pg_base + ARR_W'(i)] <= pagebuf[i];
         if (do_prog && !boot_r)
            mem_user[pg_base + ARR_W'(i)] <= pagebuf[i];
      end
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         if (do_erase && boot_r)  mem_boot[i] <= ERASED_BYTE;
         if (do_erase && !boot_r) mem_user[i] <= ERASED_BYTE;
      end
   end

   // Array read follows the address lines combinationally, so the byte
   // lands one clock after the address, like every other output
   // Output stage; only reads, no identification data exists
   logic [7:0] dout_nxt;
   always_comb begin
      dout_nxt = 8'h00;
      unique case (omode_r)
         O_MEM:  dout_nxt = boot_r ? mem_boot[bus.addr[ARR_W-1:0]]
                                   : mem_user[bus.addr[ARR_W-1:0]];
         O_POLL: dout_nxt = {poll_r, 6'h00};
         O_STAT: dout_nxt = stat_r;
         default: dout_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         data_out   <= 8'h00;
         data_oe    <= 8'h00;
         ready      <= 1'b0;
         busy       <= 1'b0;
         boot_array <= 1'b0;
      end else begin
         data_out   <= dout_nxt;
         data_oe    <= {8{rd_cyc && state_r != S_SETUP}};
         ready      <= state_nxt != S_SETUP;
         busy       <= state_nxt == S_BUSY;
         boot_array <= boot_nxt;
      end
   end
endmodule : ppm_seq

// ===== testbench/ppm_seq_asserts.sv
// Port-level checker for the flash sequencer
`timescale 1ns/1ps
module ppm_seq_asserts #(
   parameter int unsigned SETUP_CYCLES = 16,
   parameter int unsigned PROG_CYCLES  = 64,
   parameter int unsigned ERASE_CYCLES = 256
) (
   input wire logic              clk_sys,   // System clock
   input wire logic              rst_n,     // Synchronous reset
   input wire ppm_pkg::ppm_bus_t bus,       // Programmer lines
   input wire logic [7:0]        data_out,  // Data bus value
   input wire logic [7:0]        data_oe,   // Data bus enable
   input wire logic              ready,     // Setup over
   input wire logic              busy,      // Operation running
   input wire logic              boot_array // Boot array selected
);
   import ppm_pkg::*;
   logic [31:0] up_r, up_nxt, bcnt_r, bcnt_nxt;
   logic [3:0]  quiet_r, quiet_nxt;
   logic        rd_cyc;
   assign rd_cyc = !bus.ce_n && !bus.oe_n && bus.we_n;
   // Quiet counts cycles with no write, no operation and setup over
   always_comb begin
      up_nxt = (up_r < SETUP_CYCLES + 8) ? up_r + 32'h1 : up_r;
      bcnt_nxt = busy ? bcnt_r + 32'h1 : 32'h0;
      quiet_nxt = (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;
      if (!bus.we_n || busy || !ready)
         quiet_nxt = 4'h0;
      if (!rst_n) begin
         up_nxt = 32'h0;
         bcnt_nxt = 32'h0;
         quiet_nxt = 4'h0;
      end
   end
   always_ff @(posedge clk_sys) begin
      up_r <= up_nxt;
      bcnt_r <= bcnt_nxt;
      quiet_r <= quiet_nxt;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   setup_early_a: assert property (ready |-> up_r >= SETUP_CYCLES - 1)
      else $error("ready rose before setup ended");
   setup_late_a: assert property (up_r == SETUP_CYCLES + 4 |-> ready)
      else $error("ready missing after setup");
   busy_ready_a: assert property (busy |-> ready)
      else $error("busy during setup");
   read_drive_a: assert property ((ready && rd_cyc) [*3] |-> data_oe == 8'hff)
      else $error("data bus not driven in read");
   idle_float_a: assert property (bus.ce_n [*3] |-> data_oe == 8'h00)
      else $error("data bus driven while deselected");
   write_float_a: assert property ((!bus.we_n) [*3] |-> data_oe == 8'h00)
      else $error("data bus driven in write");
   busy_poll_a: assert property ((busy && rd_cyc) [*4] |-> data_out == 8'h00)
      else $error("poll byte wrong while busy");
   busy_len_a: assert property ($fell(busy) |->
      bcnt_r inside {[PROG_CYCLES-1:PROG_CYCLES+1],
                     [ERASE_CYCLES-1:ERASE_CYCLES+1]})
      else $error("operation length wrong");
   hold_data_a: assert property ((quiet_r == 4'hf && rd_cyc
      && $stable(bus.addr)) [*3] |-> $stable(data_out))
      else $error("output byte changed without a command");
   boot_change_a: assert property ($changed(boot_array) |-> quiet_r < 4'h8)
      else $error("array select changed without a write");
endmodule : ppm_seq_asserts

bind ppm_seq ppm_seq_asserts #(
   .SETUP_CYCLES(SETUP_CYCLES),
   .PROG_CYCLES (PROG_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES)
) u_chk (
   .clk_sys   (clk_sys),
   .rst_n     (rst_n),
   .bus       (bus),
   .data_out  (data_out),
   .data_oe   (data_oe),
   .ready     (ready),
   .busy      (busy),
   .boot_array(boot_array)
);

// ===== testbench/ppm_prog_model.sv
// Programmer model driving the parallel bus strobes
`timescale 1ns/1ps
module ppm_prog_model (
   input wire logic         clk_sys,  // System clock
   output ppm_pkg::ppm_bus_t bus,     // Strobes, address, data
   input wire logic [7:0]   data_out, // Device data
   output logic [7:0]       rd_val,   // Last byte read
   output logic             rd_tick   // Toggles on each read
);
   import ppm_pkg::*;
   initial begin
      bus = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: 8'h5a};
      rd_val = 8'h00;
      rd_tick = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   // Strobes held two cycles so the registered edge is seen
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      cyc(1);
      bus.addr = a;
      bus.data = d;
      bus.ce_n = 1'b0;
      bus.we_n = 1'b0;
      cyc(2);
      bus.we_n = 1'b1;
      cyc(2);
      bus.ce_n = 1'b1;
      bus.data = ~d; // Released lines never keep the last value
      cyc(3);
   endtask : wr
   // Address stays at the page base for every data cycle
   task automatic page(input logic [ADDR_W-1:0] a, input logic [7:0] cmd,
                       input logic [7:0] d [PAGE_BYTES]);
      wr('0, cmd);
      for (int k = 0; k < PAGE_BYTES; k++)
         wr(a, d[k]);
   endtask : page
   task automatic rd(input logic [ADDR_W-1:0] a);
      cyc(1);
      bus.addr = a;
      bus.ce_n = 1'b0;
      bus.oe_n = 1'b0;
      cyc(3);
      rd_val = data_out;
      rd_tick = ~rd_tick;
      cyc(1);
      bus.oe_n = 1'b1;
      bus.ce_n = 1'b1;
   endtask : rd
endmodule : ppm_prog_model

// ===== testbench/ppm_seq_tb.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
module ppm_seq_tb;
   import ppm_pkg::*;
   localparam int unsigned SETUP = 32;
   logic       clk_sys, rst_n, ready, busy, boot_array, rd_tick;
   ppm_bus_t   bus;
   logic [7:0] data_out, data_oe, rd_val, lfsr;
   logic [7:0] pg [PAGE_BYTES];
   logic [7:0] exp_q [$];
   int         n_errors, samples_checked;
   ppm_seq #(.SETUP_CYCLES(SETUP)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .data_out(data_out),
      .data_oe(data_oe), .ready(ready), .busy(busy),
      .boot_array(boot_array));
   ppm_prog_model u_prog (
      .clk_sys(clk_sys), .bus(bus), .data_out(data_out),
      .rd_val(rd_val), .rd_tick(rd_tick));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] nxt(input logic [7:0] l);
      return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
   endfunction : nxt
   task automatic finish_test;
      if (n_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : cmp
   always @(rd_tick)
      if (exp_q.size() > 0)
         cmp("read byte", exp_q.pop_front(), rd_val);
   task automatic chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_prog.rd(a);
   endtask : chk
   // Bounded wait for setup end or for the operation to finish
   task automatic wait_on(input bit rdy);
      int i;
      i = 0;
      while ((rdy ? ready !== 1'b1 : busy !== 1'b0) && i < 2000) begin
         @(negedge clk_sys);
         i++;
      end
      if (i >= 2000) begin
         n_errors++;
         finish_test();
      end
   endtask : wait_on
   task automatic cmd2(input logic [7:0] c);
      u_prog.wr('0, c);
      u_prog.wr('0, c);
   endtask : cmd2
   initial begin
      rst_n = 1'b0;
      lfsr = 8'h4e;
      n_errors = 0;
      samples_checked = 0;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1; // never reset while an operation runs
      cmd2(CMD_STATUS); // dropped during setup
      wait_on(1'b1);
      cmd2(CMD_ERASE_USER);
      chk('0, 8'h00);
      wait_on(1'b0);
      chk('0, 8'hc0);
      u_prog.wr('0, CMD_READ_USER);
      for (int k = 0; k < 4; k++)
         chk(ADDR_W'(k * 200), ERASED_BYTE);
      for (int k = 0; k < PAGE_BYTES; k++) begin
         lfsr = nxt(lfsr);
         pg[k] = (k < 100) ? lfsr : ERASED_BYTE;
      end
      u_prog.page(19'h00080, CMD_PROG_USER, pg);
      chk('0, 8'h00);
      wait_on(1'b0);
      chk('0, 8'hc0);
      chk('0, 8'hc0);
      u_prog.wr('0, CMD_READ_USER);
      for (int k = 0; k < PAGE_BYTES; k++)
         chk(ADDR_W'(32'h80 + k), pg[k]);
      // Second program of a page, then a misaligned page base
      u_prog.page(19'h00080, CMD_PROG_USER, pg);
      wait_on(1'b0);
      chk('0, 8'h80);
      cmd2(CMD_STATUS);
      chk('0, 8'ha2);
      chk('0, 8'ha2);
      u_prog.page(19'h00101, CMD_PROG_USER, pg);
      wait_on(1'b0);
      chk('0, 8'h80);
      cmd2(CMD_STATUS);
      chk('0, 8'ha1);
      u_prog.wr('0, 8'h90); // no identification mode
      chk('0, 8'he1);
      cmd2(CMD_ERASE_BOOT);
      cmp("boot_array", 8'h01, {7'h00, boot_array});
      wait_on(1'b0);
      chk('0, 8'hc0);
      u_prog.wr('0, CMD_READ_USER);
      cmp("boot_array", 8'h00, {7'h00, boot_array});
      chk(19'h00080, pg[0]);
      u_prog.wr('0, CMD_READ_BOOT);
      cmp("boot_array", 8'h01, {7'h00, boot_array});
      chk(19'h00080, ERASED_BYTE);
      // Array contents are only known after an erase, so power-up read mode
      // is checked after a second reset with the bus idle
      rst_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      wait_on(1'b1);
      chk(19'h00010, ERASED_BYTE);
      repeat (4) @(negedge clk_sys);
      finish_test();
   end
endmodule : ppm_seq_tb
